//--- design/bsr_defs.svh
// Purpose: Offsets, field positions, reset values and sizes of the shift register block
// Assumes: Included by design files by bare name
// Notes: Byte addresses on a 32-bit APB word grid
//
// Overview of operation
// [R1] Four stages, four parallel inputs and outputs, right and left serial inputs.
// [R2] Both mode selects high: parallel data loads into the stages at the rising edge.
// [R3] During a parallel load both serial inputs are ignored.
// [R4] Only low select high: shift from first toward last stage, right serial enters first.
// [R5] Only high select high: shift from last toward first stage, left serial enters last.
// [R6] Both mode selects low: all four stages hold across rising edges.
// [R7] Clear low forces all outputs low at once, regardless of clock and inputs.
// [R8] The driving logic changes mode selects only while the clock is high.
// [R9] With clear released, stages change only on rising clock edges.
`ifndef BSR_DEFS_SVH
`define BSR_DEFS_SVH

`define BSR_ADDR_W 12
`define BSR_ADDR_CMD 12'h000
`define BSR_ADDR_STATUS 12'h004
`define BSR_ADDR_CTRL 12'h008

`define BSR_STAGES 4
`define BSR_CMD_W 8
`define BSR_CMD_PAR_LSB 0
`define BSR_CMD_SER_R 4
`define BSR_CMD_SER_L 5
`define BSR_CMD_MODE_LSB 6

`define BSR_STATUS_STAGE_LSB 0
`define BSR_STATUS_EMPTY 4
`define BSR_STATUS_FULL 5
`define BSR_STATUS_LEVEL_LSB 8

`define BSR_CTRL_RUN 0
`define BSR_CTRL_RUN_RST 1'b1

`define BSR_FIFO_DEPTH 8

`endif

//--- design/bsr_pkg.sv
// Purpose: Types of the shift register block
// Assumes: Mode code is {mode_select_high, mode_select_low}
// Notes: Codes match the command word mode field
package bsr_pkg;

  typedef enum logic [1:0] {
    BSR_MODE_HOLD = 2'b00,
    BSR_MODE_RIGHT = 2'b01,
    BSR_MODE_LEFT = 2'b10,
    BSR_MODE_LOAD = 2'b11
  } bsr_mode_t;

endpackage : bsr_pkg

//--- design/bsr_mem.sv
// Purpose: Small word store for the command queue
// Assumes: Single clock, one write and one read port
// Notes: Registered read data, write-first on address match
`timescale 1ns/1ps
module bsr_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  localparam int AW = $clog2(DEPTH)
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] store [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      store[waddr] <= wdata;
    end
  end

  // Bypass keeps the head word current when it is written this cycle
  always_ff @(posedge clk)
  begin
    if (we && (waddr == raddr))
    begin
      rdata <= wdata;
    end
    else
    begin
      rdata <= store[raddr];
    end
  end

endmodule : bsr_mem

//--- design/bsr_fifo.sv
// Purpose: Command queue with valid and ready on both sides
// Assumes: DEPTH of at least two
// Notes: Head word always presented from a registered memory read
`timescale 1ns/1ps
module bsr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  localparam int AW = $clog2(DEPTH),
  localparam int LW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [LW-1:0] level
);

  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW-1:0] raddr;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1))
    begin
      return '0;
    end
    return p + 1'b1;
  endfunction : ptr_inc

  assign in_ready = (level != LW'(DEPTH));
  assign out_valid = (level != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign raddr = pop ? ptr_inc(rptr) : rptr;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr <= ptr_inc(wptr);
      end
      if (pop)
      begin
        rptr <= ptr_inc(rptr);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      level <= '0;
    end
    else if (push && !pop)
    begin
      level <= level + 1'b1;
    end
    else if (pop && !push)
    begin
      level <= level - 1'b1;
    end
  end

  bsr_mem #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_mem (
    .clk(clk),
    .we(push),
    .waddr(wptr),
    .wdata(in_data),
    .raddr(raddr),
    .rdata(out_data)
  );

endmodule : bsr_fifo

//--- design/bsr_top.sv
// Purpose: Four-stage bidirectional universal shift register behind an APB slave
// Assumes: Commands queued over APB; one queued command applied per rising CLK edge while the CTRL run bit is set
// Notes: CLEAR_N clears the stages asynchronously; RST is synchronous
`timescale 1ns/1ps
`include "bsr_defs.svh"
module bsr_top #(
  parameter int FIFO_DEPTH = `BSR_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Direct clear, active low
  input wire logic CLEAR_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`BSR_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Parallel stage outputs
  output logic [`BSR_STAGES-1:0] Q
);

  import bsr_pkg::*;

  localparam int LVL_W = $clog2(FIFO_DEPTH + 1);

  logic access;
  logic done;
  logic stall;
  logic cmd_wr;
  logic ctrl_run;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic apply;
  logic [`BSR_CMD_W-1:0] fifo_out_data;
  logic [`BSR_CMD_W-1:0] last_cmd;
  logic [LVL_W-1:0] fifo_level;
  logic [31:0] next_prdata;
  logic [`BSR_STAGES-1:0] cmd_par;
  logic cmd_ser_r;
  logic cmd_ser_l;
  bsr_mode_t cmd_mode;

  // Next stage contents for one mode
  function automatic logic [`BSR_STAGES-1:0] stage_next(
    input logic [`BSR_STAGES-1:0] cur,
    input bsr_mode_t mode,
    input logic [`BSR_STAGES-1:0] par,
    input logic ser_r,
    input logic ser_l
  );
    logic [`BSR_STAGES-1:0] nxt;
    nxt = cur;
    unique case (mode)
      BSR_MODE_HOLD:
      begin
        nxt = cur; // R6
      end
      BSR_MODE_RIGHT:
      begin
        nxt = {cur[`BSR_STAGES-2:0], ser_r}; // R4
      end
      BSR_MODE_LEFT:
      begin
        nxt = {ser_l, cur[`BSR_STAGES-1:1]}; // R5
      end
      BSR_MODE_LOAD:
      begin
        nxt = par; // R2 R3
      end
    endcase
    return nxt;
  endfunction : stage_next

  // Address decode
  function automatic logic addr_mapped(input logic [`BSR_ADDR_W-1:0] addr);
    return (addr == `BSR_ADDR_CMD) || (addr == `BSR_ADDR_STATUS) ||
      (addr == `BSR_ADDR_CTRL);
  endfunction : addr_mapped

  // Command word fields
  assign cmd_par = fifo_out_data[`BSR_CMD_PAR_LSB +: `BSR_STAGES];
  assign cmd_ser_r = fifo_out_data[`BSR_CMD_SER_R];
  assign cmd_ser_l = fifo_out_data[`BSR_CMD_SER_L];
  assign cmd_mode = bsr_mode_t'(fifo_out_data[`BSR_CMD_MODE_LSB +: 2]);

  // APB phase decode
  assign access = PSEL && PENABLE && !PREADY;
  assign done = PSEL && PENABLE && PREADY;
  assign cmd_wr = PWRITE && (PADDR == `BSR_ADDR_CMD);
  assign stall = access && cmd_wr && !fifo_in_ready;
  assign fifo_in_valid = done && cmd_wr;

  // One queued command per rising edge while running
  assign apply = fifo_out_valid && ctrl_run;

  bsr_fifo #(
    .WIDTH(`BSR_CMD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(PWDATA[`BSR_CMD_W-1:0]),
    .out_valid(fifo_out_valid),
    .out_ready(ctrl_run),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // Stage register with direct clear
  always_ff @(posedge CLK or negedge CLEAR_N)
  begin
    if (!CLEAR_N)
    begin
      Q <= 4'h0; // R7
    end
    else if (RST)
    begin
      Q <= 4'h0; // R1
    end
    else if (apply)
    begin
      Q <= stage_next(Q, cmd_mode, cmd_par, cmd_ser_r, cmd_ser_l); // R9
    end
  end

  // Last applied command
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      last_cmd <= '0;
    end
    else if (apply)
    begin
      last_cmd <= fifo_out_data;
    end
  end

  // Run control
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ctrl_run <= `BSR_CTRL_RUN_RST;
    end
    else if (done && PWRITE && (PADDR == `BSR_ADDR_CTRL))
    begin
      ctrl_run <= PWDATA[`BSR_CTRL_RUN];
    end
  end

  // Read data
  always_comb
  begin
    next_prdata = 32'h0;
    case (PADDR)
      `BSR_ADDR_CMD:
      begin
        next_prdata[`BSR_CMD_W-1:0] = last_cmd;
      end
      `BSR_ADDR_STATUS:
      begin
        next_prdata[`BSR_STATUS_STAGE_LSB +: `BSR_STAGES] = Q;
        next_prdata[`BSR_STATUS_EMPTY] = !fifo_out_valid;
        next_prdata[`BSR_STATUS_FULL] = !fifo_in_ready;
        next_prdata[`BSR_STATUS_LEVEL_LSB +: LVL_W] = fifo_level;
      end
      `BSR_ADDR_CTRL:
      begin
        next_prdata[`BSR_CTRL_RUN] = ctrl_run;
      end
      default:
      begin
        next_prdata = 32'h0;
      end
    endcase
  end

  // APB answer; a full queue holds PREADY low on a command write
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= access && !stall;
      PSLVERR <= access && !stall && !addr_mapped(PADDR);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      PRDATA <= 32'h0;
    end
    else if (access && !stall && !PWRITE)
    begin
      PRDATA <= next_prdata;
    end
  end

  // Checks
  property p_reset_zero;
    @(posedge CLK) disable iff (RST)
    $fell(RST) && CLEAR_N |-> Q == 4'h0;
  endproperty
  a_reset_zero: assert property (p_reset_zero) // R1
    else $error("Stages not empty after reset");

  property p_load;
    @(posedge CLK) disable iff (RST)
    (apply && CLEAR_N && cmd_mode == BSR_MODE_LOAD) ##1 CLEAR_N |-> Q == $past(cmd_par);
  endproperty
  a_load: assert property (p_load) // R2
    else $error("Parallel load mismatch");

  property p_load_no_serial;
    @(posedge CLK) disable iff (RST)
    (apply && CLEAR_N && cmd_mode == BSR_MODE_LOAD &&
      (cmd_ser_r != cmd_par[0] || cmd_ser_l != cmd_par[3])) ##1 CLEAR_N
    |-> Q[0] == $past(cmd_par[0]) && Q[3] == $past(cmd_par[3]);
  endproperty
  a_load_no_serial: assert property (p_load_no_serial) // R3
    else $error("Serial data entered during load");

  property p_right;
    @(posedge CLK) disable iff (RST)
    (apply && CLEAR_N && cmd_mode == BSR_MODE_RIGHT) ##1 CLEAR_N
    |-> Q == {$past(Q[2:0]), $past(cmd_ser_r)};
  endproperty
  a_right: assert property (p_right) // R4
    else $error("Right shift mismatch");

  property p_left;
    @(posedge CLK) disable iff (RST)
    (apply && CLEAR_N && cmd_mode == BSR_MODE_LEFT) ##1 CLEAR_N
    |-> Q == {$past(cmd_ser_l), $past(Q[3:1])};
  endproperty
  a_left: assert property (p_left) // R5
    else $error("Left shift mismatch");

  property p_hold;
    @(posedge CLK) disable iff (RST)
    (apply && cmd_mode == BSR_MODE_HOLD && CLEAR_N) ##1 CLEAR_N |-> $stable(Q);
  endproperty
  a_hold: assert property (p_hold) // R6
    else $error("Stages changed in hold");

  property p_clear;
    @(posedge CLK) disable iff (RST)
    !CLEAR_N |-> Q == 4'h0;
  endproperty
  a_clear: assert property (p_clear) // R7
    else $error("Stages not cleared");

  property p_idle;
    @(posedge CLK) disable iff (RST)
    (!apply && CLEAR_N) [*3] |-> Q == $past(Q, 2);
  endproperty
  a_idle: assert property (p_idle) // R9
    else $error("Stages changed without an applied edge");

  property p_full_stall;
    @(posedge CLK) disable iff (RST)
    stall |=> !PREADY ##1 (PREADY || !fifo_in_ready || !PSEL);
  endproperty
  a_full_stall: assert property (p_full_stall)
    else $error("Write completed into a full queue");

endmodule : bsr_top

//--- tb/bsr_host.sv
// Purpose: APB master standing in for the surrounding system logic
// Assumes: One transfer per go pulse, request held until pready
// Notes: Released address and data show the inverse of the last value
`timescale 1ns/1ps
`include "bsr_defs.svh"
module bsr_host (
  // Clock, reset and request
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic wr,
  input wire logic [`BSR_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  // Result
  output logic done,
  output logic err,
  output logic [31:0] rdata,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [`BSR_ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata
);
  // Signals change only right after a rising edge
  always_ff @(posedge clk)
  begin
    done <= 1'b0;
    if (rst)
    begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
    else if (go && !psel)
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
    end
    else if (psel && !penable)
      penable <= 1'b1;
    else if (penable && pready)
    begin
      psel <= 1'b0;
      penable <= 1'b0;
      done <= 1'b1;
      err <= pslverr;
      rdata <= prdata;
      paddr <= ~paddr;
      pwdata <= ~pwdata;
    end
  end
endmodule : bsr_host

//--- tb/tb.sv
// Purpose: Self-checking bench of the shift register block
// Assumes: Commands pushed over APB, Q watched at the port
// Notes: Expected stage values kept in q_exp
`timescale 1ns/1ps
`include "bsr_defs.svh"
module tb;
  import bsr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clear_n = 1'b1;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic done, err, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] rdata, pwdata, prdata;
  logic [3:0] q;
  logic [3:0] q_exp = 4'h0;
  int err_total = 0;
  int checks_done = 0;

  always #2.5 clk = ~clk;

  bsr_top #(.FIFO_DEPTH(8)) u_bsr_top (.CLK(clk), .RST(rst), .CLEAR_N(clear_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .Q(q));
  bsr_host u_bsr_host (.clk(clk), .rst(rst), .go(go), .wr(wr), .addr(addr),
    .wdata(wdata), .done(done), .err(err), .rdata(rdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata));

  task automatic tally_and_finish;
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    wr <= w;
    addr <= a;
    wdata <= d;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < 64 && done !== 1'b1; i++)
      @(posedge clk);
    if (done !== 1'b1)
    begin
      err_total++;
      tally_and_finish();
    end
  endtask : apb

  task automatic send(input bsr_mode_t m, input logic l, input logic r, input logic [3:0] p);
    apb(1'b1, `BSR_ADDR_CMD, {24'h0, m, l, r, p});
  endtask : send

  // Poll until the queue drains, then compare the stages
  task automatic settle(input string what);
    int i;
    for (i = 0; i < 20; i++)
    begin
      apb(1'b0, `BSR_ADDR_STATUS, 32'h0);
      if (rdata[`BSR_STATUS_EMPTY] === 1'b1)
        break;
    end
    if (rdata[`BSR_STATUS_EMPTY] !== 1'b1)
    begin
      err_total++;
      tally_and_finish();
    end
    chk(what, {28'h0, q}, {28'h0, q_exp});
  endtask : settle

  task automatic t_reset;
    chk("reset q", {28'h0, q}, 32'h0);
    apb(1'b0, `BSR_ADDR_STATUS, 32'h0);
    chk("reset status", rdata, 32'h10);
    apb(1'b0, `BSR_ADDR_CTRL, 32'h0);
    chk("reset ctrl", rdata, 32'h1);
  endtask : t_reset

  task automatic t_load;
    send(BSR_MODE_LOAD, 1'b1, 1'b1, 4'hA);
    q_exp = 4'hA;
    settle("load a");
    send(BSR_MODE_LOAD, 1'b0, 1'b0, 4'h5);
    q_exp = 4'h5;
    settle("load 5");
    apb(1'b0, `BSR_ADDR_CMD, 32'h0);
    chk("last cmd", rdata, 32'hC5);
  endtask : t_load

  task automatic t_shift;
    int i;
    logic b;
    for (i = 0; i < 4; i++)
    begin
      b = i[0];
      send(BSR_MODE_RIGHT, ~b, b, ~q_exp);
      q_exp = {q_exp[2:0], b};
      settle("right");
    end
    for (i = 0; i < 4; i++)
    begin
      b = ~i[1];
      send(BSR_MODE_LEFT, b, ~b, ~q_exp);
      q_exp = {b, q_exp[3:1]};
      settle("left");
    end
    send(BSR_MODE_HOLD, 1'b1, 1'b1, ~q_exp);
    settle("hold");
  endtask : t_shift

  task automatic t_clear;
    @(posedge clk);
    clear_n <= 1'b0;
    #1;
    chk("clear now", {28'h0, q}, 32'h0);
    @(posedge clk);
    send(BSR_MODE_LOAD, 1'b1, 1'b1, 4'hF);
    q_exp = 4'h0;
    settle("clear held");
    clear_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("after clear", {28'h0, q}, 32'h0);
  endtask : t_clear

  task automatic t_fifo;
    int i;
    apb(1'b1, `BSR_ADDR_CTRL, 32'h0);
    for (i = 0; i < 8; i++)
      send(BSR_MODE_RIGHT, 1'b0, 1'b1, 4'h0);
    apb(1'b0, `BSR_ADDR_STATUS, 32'h0);
    chk("full status", rdata, 32'h820 | q_exp);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rdata, 32'h0);
    apb(1'b1, `BSR_ADDR_CTRL, 32'h1);
    q_exp = 4'hF;
    settle("drain");
  endtask : t_fifo

  // Ninth command into a stopped full queue stalls; a mid-run reset frees the bus
  task automatic t_stall;
    int i;
    apb(1'b1, `BSR_ADDR_CTRL, 32'h0);
    for (i = 0; i < 8; i++)
      send(BSR_MODE_LOAD, 1'b0, 1'b0, 4'h9);
    chk("stopped q", {28'h0, q}, {28'h0, q_exp});
    wr <= 1'b1;
    addr <= `BSR_ADDR_CMD;
    wdata <= 32'hC6;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk);
      if (done === 1'b1)
        break;
    end
    chk("stalled done", {31'h0, done}, 32'h0);
    chk("stalled q", {28'h0, q}, {28'h0, q_exp});
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    q_exp = 4'h0;
    t_reset();
  endtask : t_stall

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_load();
    t_shift();
    t_clear();
    t_fifo();
    t_stall();
    tally_and_finish();
  end
endmodule : tb
